// [include/gpo_cal_defs.svh]
`ifndef GPO_CAL_DEFS_SVH
`define GPO_CAL_DEFS_SVH

// ==========================================================
// register select codes on the serial port
`define ADDR_GPO_CTRL     3'h5
`define ADDR_OFFSET_COEF  3'h6
`define ADDR_FULL_COEF    3'h7

// ==========================================================
// output control fields
`define GPO_UPPER_EN_BIT  5
`define GPO_LOWER_EN_BIT  4
`define GPO_RESET         8'h00
`define GPO_WRITE_MASK    8'h3f

// ==========================================================
// coefficient reset values
`define OFFSET_RESET      24'h800000
`define FULL_RESET_DFLT   24'h500000

// ==========================================================
// serial framing
`define CMD_BITS          8
`define CMD_READ_BIT      6
`define CMD_RS_MSB        5
`define CMD_RS_LSB        3

`endif

// [include/gpo_cal_pkg.sv]
package gpo_cal_pkg;
  typedef enum logic [2:0] {
    ST_CMD  = 3'h1,
    ST_WR   = 3'h2,
    ST_RD   = 3'h4
  } spi_state_e;
  typedef logic [23:0] coef_t;
endpackage

// [include/gpo_cal_if.sv]
`timescale 1ns/1ps
interface gpo_cal_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [2:0] addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  modport master (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport slave  (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// [rtl/gpo_cal_spi.sv]
`timescale 1ns/1ps
`include "gpo_cal_defs.svh"
// serial shift engine; SCLK, CS_N and DIN are already synchronised to clk
module gpo_cal_spi (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   cs_n,
  input  wire logic   sclk,
  input  wire logic   din,
  output logic        dout,
  output logic        dout_en,
  gpo_cal_if.master   bus
);
  gpo_cal_pkg::spi_state_e state;
  logic       sclk_d;
  logic [4:0] cnt;
  logic [4:0] len;
  logic [23:0] shreg;
  logic       rise;
  logic       fall;

  assign rise = sclk & ~sclk_d;
  assign fall = ~sclk & sclk_d;

  // ==========================================================
  // register width: 8 bits for output control, 24 for the pair
  function automatic logic [4:0] width_of(input logic [2:0] a);
    width_of = (a == `ADDR_GPO_CTRL) ? 5'd8 : 5'd24;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
    end
  end

  // ==========================================================
  // frame engine, mode 3: sample on rising, shift out on falling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= gpo_cal_pkg::ST_CMD;
      cnt     <= 5'h0;
      len     <= 5'h0;
      shreg   <= 24'h0;
      bus.addr <= 3'h0;
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      bus.wdata <= 24'h0;
      dout    <= 1'b1;
      dout_en <= 1'b0;
    end else begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      if (cs_n) begin
        state   <= gpo_cal_pkg::ST_CMD;
        cnt     <= 5'h0;
        dout_en <= 1'b0;
        dout    <= 1'b1;
      end else begin
        dout_en <= 1'b1;
        unique case (state)
          gpo_cal_pkg::ST_CMD: begin
            if (rise) begin
              shreg <= {shreg[22:0], din};
              cnt   <= cnt + 5'h1;
              if (cnt == 5'(`CMD_BITS - 1)) begin
                bus.addr <= shreg[`CMD_RS_MSB-1:`CMD_RS_LSB-1];
                len      <= width_of(shreg[`CMD_RS_MSB-1:`CMD_RS_LSB-1]);
                cnt      <= 5'h0;
                if (shreg[`CMD_READ_BIT-1]) begin
                  bus.rd_stb <= 1'b1;
                  state      <= gpo_cal_pkg::ST_RD;
                end else begin
                  state <= gpo_cal_pkg::ST_WR;
                end
              end
            end
          end
          gpo_cal_pkg::ST_WR: begin
            if (rise) begin
              shreg <= {shreg[22:0], din};
              cnt   <= cnt + 5'h1;
              if (cnt == len - 5'h1) begin
                bus.wdata  <= {shreg[22:0], din};
                bus.wr_stb <= 1'b1;
                cnt        <= 5'h0;
                state      <= gpo_cal_pkg::ST_CMD;
              end
            end
          end
          gpo_cal_pkg::ST_RD: begin
            if (fall) begin
              dout <= bus.rdata[len - 5'h1 - cnt];
              cnt  <= cnt + 5'h1;
            end else if (rise && cnt == len) begin
              cnt   <= 5'h0;
              state <= gpo_cal_pkg::ST_CMD;
            end
          end
        endcase
      end
    end
  end
endmodule

// [rtl/gpo_cal_regs.sv]
`timescale 1ns/1ps
`include "gpo_cal_defs.svh"
// Operation
// R1 - upper enable drives output 3 from bit
// R2 - upper enable: bit 3 reads pin 3
// R3 - upper enable drives output 2 from bit
// R4 - upper enable: bit 2 reads pin 2
// R5 - lower enable drives output 1 from bit
// R6 - lower enable: bit 1 reads pin 1
// R7 - lower enable drives output 0 from bit
// R8 - lower enable: bit 0 reads pin 0
// R9 - offset coefficient 24 bit, resets 0x800000
// R10 - zero-scale calibration done overwrites offset
// R11 - host idles converter before offset write
// R12 - full-scale coefficient loads factory value
// R13 - host idles converter before full-scale write
// R14 - calibration done or write replaces full-scale
// R15 - registers reachable only through serial port
// R16 - upper enable bit 5, lower bit 4
// R17 - lower enable clear tristates outputs 1,0
// R18 - host writes zero to top two bits
// R19 - disabled pair reads last written data
module gpo_cal_regs #(
  parameter logic [23:0] FACTORY_FULL_SCALE = `FULL_RESET_DFLT
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic        DIN,
  output logic             DOUT,
  output logic             DOUT_EN,
  input  wire logic [3:0]  GP_PIN_IN,
  output logic      [3:0]  GP_PIN_OUT,
  output logic      [3:0]  GP_PIN_OE,
  input  wire logic        CONV_IDLE,
  input  wire logic        ZERO_CAL_DONE,
  input  wire logic [23:0] ZERO_CAL_VALUE,
  input  wire logic        FULL_CAL_DONE,
  input  wire logic [23:0] FULL_CAL_VALUE,
  output logic             WRITE_WHILE_BUSY
);
  gpo_cal_if bus ();

  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [7:0] general_output_control;
  gpo_cal_pkg::coef_t offset_coefficient;
  gpo_cal_pkg::coef_t full_scale_coefficient;
  logic       upper_pair_enable;
  logic       lower_pair_enable;
  logic [3:0] pair_en;
  logic [3:0] read_bits;

  // ==========================================================
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h3;
      din_sync  <= 2'h0;
      pin_s1    <= 4'h0;
      pin_s2    <= 4'h0;
    end else begin
      cs_sync   <= {cs_sync[0], CS_N};
      sclk_sync <= {sclk_sync[0], SCLK};
      din_sync  <= {din_sync[0], DIN};
      pin_s1    <= GP_PIN_IN;
      pin_s2    <= pin_s1;
    end
  end

  // serial port is the only host path into the registers
  gpo_cal_spi u_spi ( // see R15
    .clk     (CLK),
    .rst     (RST),
    .cs_n    (cs_sync[1]),
    .sclk    (sclk_sync[1]),
    .din     (din_sync[1]),
    .dout    (DOUT),
    .dout_en (DOUT_EN),
    .bus     (bus.master)
  );

  // ==========================================================
  // output control register
  // top two bits are held at zero whatever the host sends
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      general_output_control <= `GPO_RESET;
    end else if (bus.wr_stb && bus.addr == `ADDR_GPO_CTRL) begin
      general_output_control <= bus.wdata[7:0] & `GPO_WRITE_MASK; // see R18
    end
  end

  assign upper_pair_enable = general_output_control[`GPO_UPPER_EN_BIT]; // see R16
  assign lower_pair_enable = general_output_control[`GPO_LOWER_EN_BIT]; // see R16
  assign pair_en = {upper_pair_enable, upper_pair_enable, lower_pair_enable, lower_pair_enable};

  // data outputs come from flops: registered level bits gated by the pair enables
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      GP_PIN_OUT <= 4'h0;
      GP_PIN_OE  <= 4'h0;
    end else begin
      GP_PIN_OUT <= general_output_control[3:0] & pair_en; // see R1 R3 R5 R7
      GP_PIN_OE  <= pair_en; // see R17
    end
  end

  // enabled pair reports the pin, disabled pair the stored bit
  assign read_bits = (pair_en & pin_s2) | (~pair_en & general_output_control[3:0]); // see R2 R4 R6 R8 R19

  // ==========================================================
  // calibration coefficients
  // a calibration result in the same cycle as a host write wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      offset_coefficient <= `OFFSET_RESET; // see R9
    end else if (ZERO_CAL_DONE) begin
      offset_coefficient <= ZERO_CAL_VALUE; // see R10
    end else if (bus.wr_stb && bus.addr == `ADDR_OFFSET_COEF) begin
      offset_coefficient <= bus.wdata; // see R9
    end
  end

  // factory value is a constant per die, loaded at reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      full_scale_coefficient <= FACTORY_FULL_SCALE; // see R12
    end else if (FULL_CAL_DONE) begin
      full_scale_coefficient <= FULL_CAL_VALUE; // see R14
    end else if (bus.wr_stb && bus.addr == `ADDR_FULL_COEF) begin
      full_scale_coefficient <= bus.wdata; // see R14
    end
  end

  // flags a coefficient write made while converting; the write still lands unless that coefficient's calibration result arrives in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WRITE_WHILE_BUSY <= 1'b0;
    end else begin
      WRITE_WHILE_BUSY <= bus.wr_stb && !CONV_IDLE &&
                          (bus.addr == `ADDR_OFFSET_COEF || bus.addr == `ADDR_FULL_COEF); // see R11 R13
    end
  end

  // ==========================================================
  // read mux; unmapped selects read zero
  always_comb begin
    unique case (bus.addr)
      `ADDR_GPO_CTRL:    bus.rdata = {16'h0, general_output_control[7:4], read_bits};
      `ADDR_OFFSET_COEF: bus.rdata = offset_coefficient;
      `ADDR_FULL_COEF:   bus.rdata = full_scale_coefficient;
      default:           bus.rdata = 24'h0;
    endcase
  end
endmodule

// [sim/gpo_cal_regs_properties.sv]
`timescale 1ns/1ps
// ==========================================
// port checks
module gpo_cal_regs_properties (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       SCLK,
  input wire logic       DOUT,
  input wire logic       DOUT_EN,
  input wire logic [3:0] GP_PIN_OUT,
  input wire logic [3:0] GP_PIN_OE,
  input wire logic       CONV_IDLE,
  input wire logic       WRITE_WHILE_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  chk_upper_pair_oe: assert property (GP_PIN_OE[3] == GP_PIN_OE[2])
    else $error("upper enables differ");
  chk_lower_pair_oe: assert property (GP_PIN_OE[1] == GP_PIN_OE[0])
    else $error("lower enables differ");
  chk_out_needs_en: assert property ((GP_PIN_OUT & ~GP_PIN_OE) == 4'h0)
    else $error("pin driven high while disabled");
  chk_busy_pulse: assert property (WRITE_WHILE_BUSY |=> !WRITE_WHILE_BUSY)
    else $error("busy flag longer than one cycle");
  chk_busy_cause: assert property (WRITE_WHILE_BUSY |-> !$past(CONV_IDLE))
    else $error("busy flag while idle");
  chk_dout_idle: assert property (CS_N [*6] |-> DOUT && !DOUT_EN)
    else $error("serial output active outside frame");
  chk_frame_enable: assert property (!CS_N [*6] |-> DOUT_EN)
    else $error("serial output not enabled in frame");
  chk_reset_idle: assert property ($fell(RST) |-> GP_PIN_OE == 4'h0 && DOUT)
    else $error("outputs active after reset");
  chk_pins_quiet: assert property ($changed(GP_PIN_OUT) |-> $past(SCLK) && $past(SCLK, 3))
    else $error("pins changed inside a bit");
endmodule
bind gpo_cal_regs gpo_cal_regs_properties gpo_cal_regs_properties_i (.CLK(CLK), .RST(RST), .CS_N(CS_N),
  .SCLK(SCLK), .DOUT(DOUT), .DOUT_EN(DOUT_EN), .GP_PIN_OUT(GP_PIN_OUT), .GP_PIN_OE(GP_PIN_OE),
  .CONV_IDLE(CONV_IDLE), .WRITE_WHILE_BUSY(WRITE_WHILE_BUSY));

// [sim/gpo_host.sv]
`timescale 1ns/1ps
// ==========================================
// serial host, moves only on clk edges
module gpo_host (
  input  wire logic clk,
  input  wire logic dout,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  int half = 6; // port needs at least 4 clk per half period
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b1;
  end
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd << (24 - n)};
    rd = 24'h0;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
      din  <= sh[31 - i];
      repeat (half) @(posedge clk);
      if (i >= 8) rd = {rd[22:0], dout};
      sclk <= 1'b1;
    end
    repeat (half) @(posedge clk);
    cs_n <= 1'b1;
    din  <= ~din; // released line must not keep its value
    repeat (half) @(posedge clk);
  endtask
endmodule

// [sim/gpo_cal_regs_tb.sv]
`timescale 1ns/1ps
`include "gpo_cal_defs.svh"
// ==========================================
// register bank bench
module gpo_cal_regs_tb;
  localparam logic [23:0] FACT = 24'h5a5a50; // arbitrary factory value
  logic        clk = 1'b0, rst = 1'b1, idle = 1'b1, zdn = 1'b0, fdn = 1'b0, shrt = 1'b0;
  logic [23:0] zv = 24'h0, fv = 24'h0, rd;
  logic [3:0]  ext = 4'h0, pout, poe;
  logic        cs_n, sclk, din, dout, busy;
  int          num_errors = 0, total_checks = 0, nbusy = 0, cyc = 0;
  wire  [3:0]  pin = shrt ? ext : (poe & pout) | (~poe & ext);
  always #2.5 clk = ~clk;
  gpo_host gpo_host_i (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
  gpo_cal_regs #(.FACTORY_FULL_SCALE(FACT)) gpo_cal_regs_i (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_EN(),
    .GP_PIN_IN(pin), .GP_PIN_OUT(pout), .GP_PIN_OE(poe), .CONV_IDLE(idle), .ZERO_CAL_DONE(zdn),
    .ZERO_CAL_VALUE(zv), .FULL_CAL_DONE(fdn), .FULL_CAL_VALUE(fv), .WRITE_WHILE_BUSY(busy));
  always @(posedge clk) begin
    if (busy === 1'b1) nbusy++;
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic cmp(input string nm, input logic [23:0] ex, input logic [23:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic acc(input logic rw, input logic [2:0] sel, input int n, input logic [23:0] wd);
    gpo_host_i.xfer({1'b0, rw, sel, 3'h0}, n, wd, rd);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset();
    acc(1'b1, `ADDR_OFFSET_COEF, 24, 24'h0);
    cmp("offset", 24'h800000, rd);
    acc(1'b1, `ADDR_FULL_COEF, 24, 24'h0);
    cmp("fullscale", FACT, rd);
    acc(1'b1, `ADDR_GPO_CTRL, 8, 24'h0);
    cmp("control", 24'h0, rd);
  endtask
  task automatic t_gpo();
    acc(1'b0, `ADDR_GPO_CTRL, 8, 24'h3a);
    cmp("pin out", 24'ha, {20'h0, pout});
    cmp("pin oe", 24'hf, {20'h0, poe});
    shrt <= 1'b1;
    ext <= 4'h5;
    acc(1'b1, `ADDR_GPO_CTRL, 8, 24'h0);
    cmp("pin readback", 24'h35, rd);
    shrt <= 1'b0;
    ext <= 4'h0;
    acc(1'b0, `ADDR_GPO_CTRL, 8, 24'h2b);
    cmp("pin oe", 24'hc, {20'h0, poe});
    cmp("pin out", 24'h8, {20'h0, pout});
    acc(1'b1, `ADDR_GPO_CTRL, 8, 24'h0);
    cmp("stored readback", 24'h2b, rd);
  endtask
  task automatic t_coef();
    acc(1'b0, `ADDR_OFFSET_COEF, 24, 24'h123456);
    acc(1'b1, `ADDR_OFFSET_COEF, 24, 24'h0);
    cmp("offset", 24'h123456, rd);
    acc(1'b0, `ADDR_FULL_COEF, 24, 24'habcdef);
    acc(1'b1, `ADDR_FULL_COEF, 24, 24'h0);
    cmp("fullscale", 24'habcdef, rd);
    zv <= 24'h654321;
    fv <= 24'h13579b;
    zdn <= 1'b1;
    @(posedge clk);
    zdn <= 1'b0;
    fdn <= 1'b1;
    @(posedge clk);
    fdn <= 1'b0;
    acc(1'b1, `ADDR_OFFSET_COEF, 24, 24'h0);
    cmp("offset cal", 24'h654321, rd);
    acc(1'b1, `ADDR_FULL_COEF, 24, 24'h0);
    cmp("fullscale cal", 24'h13579b, rd);
    cmp("busy count", 24'h0, nbusy[23:0]);
  endtask
  task automatic t_busy();
    idle <= 1'b0;
    acc(1'b0, `ADDR_OFFSET_COEF, 24, 24'h0f0f0f);
    repeat (10) @(posedge clk);
    idle <= 1'b1;
    cmp("busy count", 24'h1, nbusy[23:0]);
    acc(1'b1, `ADDR_OFFSET_COEF, 24, 24'h0);
    cmp("offset", 24'h0f0f0f, rd);
  endtask
  task automatic t_misc();
    gpo_host_i.half = 12; // slow host
    acc(1'b0, 3'h1, 24, 24'hffffff);
    acc(1'b1, 3'h1, 24, 24'h0);
    cmp("unmapped", 24'h0, rd);
    gpo_host_i.half = 6;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    cmp("pin oe", 24'h0, {20'h0, poe});
    acc(1'b1, `ADDR_OFFSET_COEF, 24, 24'h0);
    cmp("offset", 24'h800000, rd);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_reset();
    t_gpo();
    t_coef();
    t_busy();
    t_misc();
    summarize();
  end
endmodule
